// ---- rtl/keypad_wake_pkg.sv ----
package keypad_wake_pkg;
    localparam int unsigned NPINS = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned EVT_W = 2;
    // Byte offsets
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_PIN_ENABLE = 8'h10;
    localparam logic [7:0] OFS_POLARITY = 8'h14;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h18;
    localparam logic [7:0] OFS_EVT_CLEAR = 8'h1c;
    localparam logic [7:0] OFS_EVT_ENABLE = 8'h20;
    // Status and control fields
    localparam int unsigned SC_MODE_BIT = 0;
    localparam int unsigned SC_IE_BIT = 1;
    localparam int unsigned SC_ACK_BIT = 2;
    localparam int unsigned SC_FLAG_BIT = 3;
    // Event status fields
    localparam int unsigned EVT_EDGE_BIT = 0;
    localparam int unsigned EVT_LEVEL_BIT = 1;
    // Reset values
    localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
    localparam logic [7:0] RST_POLARITY = 8'h00;
    localparam logic [1:0] RST_EVT = 2'h0;
    localparam logic RST_MODE = 1'b0;
    localparam logic RST_IE = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    // Sampled level taken as asserted until an inactive sample is seen
    localparam logic [7:0] RST_PREV_ACT = 8'hff;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Detection modes
    typedef enum logic
    {
        MODE_EDGE_ONLY = 1'b0,
        MODE_EDGE_LEVEL = 1'b1
    } detect_mode_t;
endpackage : keypad_wake_pkg

// ---- rtl/keypad_wake_unit.sv ----
// Function
// RULE1 - Eight pin enable bits; 1 makes the pin a source, 0 ignores it
// RULE2 - Eight polarity bits; 0 falling or low, 1 rising or high
// RULE3 - Up to eight pins, each enabled independently
// RULE4 - One mode bit selects edge-only or edge-and-level for all pins
// RULE5 - Falling edge: enabled input sampled 1 then 0 on bus clock
// RULE6 - Rising edge: enabled input sampled 0 then 1 on bus clock
// RULE7 - Edge counts only after the input was seen at inactive level
// RULE8 - Edge-only mode: valid edge on enabled pin sets the flag
// RULE9 - Flag set with interrupt enable 1 raises the interrupt request
// RULE10 - Edge-only mode: acknowledge write of 1 clears the flag
// RULE11 - Edge-and-level mode: edge or asserted level sets the flag
// RULE12 - Edge-and-level mode: acknowledge clears only if all enabled inputs inactive
// RULE13 - Edge-and-level mode: flag stays set if any enabled pin asserted
// RULE14 - With pull enabled, polarity 0 gives pullup, 1 gives pulldown
// RULE15 - Software masks, sets polarity, pulls, enables, acknowledges, then unmasks
// RULE16 - Status/control: flag bit 3, ack bit 2, enable bit 1, mode bit 0
// RULE17 - Flag ignores writes; acknowledge always reads zero
// RULE18 - Mode 0 is edge-only, mode 1 is edge and level
// RULE19 - Request drops with the flag; disabled pin never sets the flag (irq also stays high while an enabled event status bit is set)
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module keypad_wake_unit
    import keypad_wake_pkg::*;
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ce,
    // Pins and pull control
    input wire logic [NPINS-1:0] wake_input_pin,
    input wire logic [NPINS-1:0] port_pull_enable,
    output logic [NPINS-1:0] pull_up_en,
    output logic [NPINS-1:0] pull_down_en,
    // Interrupt
    output logic irq,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == OFS_STATUS_CONTROL) || (a == OFS_PIN_ENABLE) || (a == OFS_POLARITY)
            || (a == OFS_EVT_STATUS) || (a == OFS_EVT_CLEAR) || (a == OFS_EVT_ENABLE);
    endfunction : addr_mapped

    function automatic logic [NPINS-1:0] asserted_of(input logic [NPINS-1:0] pins,
                                                     input logic [NPINS-1:0] pol);
        asserted_of = ~(pins ^ pol);
    endfunction : asserted_of

    logic [NPINS-1:0] pin_meta_r;
    logic [NPINS-1:0] pin_sync_r;
    logic [NPINS-1:0] prev_act_r;
    logic [NPINS-1:0] pin_enable_r;
    logic [NPINS-1:0] polarity_r;
    detect_mode_t mode_r;
    logic irq_enable_r;
    logic event_flag_r;
    logic [EVT_W-1:0] evt_status_r;
    logic [EVT_W-1:0] evt_enable_r;
    logic [NPINS-1:0] act_now;
    logic [NPINS-1:0] edge_hits;
    logic edge_hit;
    logic level_any;
    logic level_hit;
    logic flag_set;
    logic ack_wr;
    logic ack_clear;
    logic [EVT_W-1:0] evt_clear;
    logic aw_got_r;
    logic w_got_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_fire;
    logic wr_lane0;
    logic rvalid_r;
    logic [DATA_W-1:0] rdata_r;
    logic [1:0] rresp_r;
    logic [ADDR_W-1:0] raddr_r;
    logic [DATA_W-1:0] rdata_nxt;

    // Pin synchroniser
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_meta_r <= 8'h00;
            pin_sync_r <= 8'h00;
        end
        else if (ce)
        begin
            pin_meta_r <= wake_input_pin;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Detection
    assign act_now = asserted_of(pin_sync_r, polarity_r); // see RULE2
    // Rising when polarity 1, falling when polarity 0, after an inactive sample
    assign edge_hits = pin_enable_r & ~prev_act_r & act_now; // see RULE5 see RULE6 see RULE7 see RULE1
    assign edge_hit = |edge_hits; // see RULE3 see RULE8
    assign level_any = |(pin_enable_r & act_now); // see RULE19
    assign level_hit = (mode_r == MODE_EDGE_LEVEL) && level_any; // see RULE11 see RULE18
    assign flag_set = edge_hit || level_hit; // see RULE4

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prev_act_r <= RST_PREV_ACT;
        end
        else if (ce)
        begin
            prev_act_r <= act_now; // see RULE5
        end
    end

    // Bus write channel
    assign s_axi_awready = ce && !aw_got_r && !bvalid_r;
    assign s_axi_wready = ce && !w_got_r && !bvalid_r;
    assign wr_fire = ce && aw_got_r && w_got_r && !bvalid_r;
    assign wr_lane0 = wr_fire && wstrb_r[0];
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= addr_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_enable_r <= RST_PIN_ENABLE;
            polarity_r <= RST_POLARITY;
            mode_r <= MODE_EDGE_ONLY;
            irq_enable_r <= RST_IE;
            evt_enable_r <= RST_EVT;
        end
        else if (ce && wr_lane0)
        begin
            unique case (awaddr_r)
                OFS_PIN_ENABLE: pin_enable_r <= wdata_r[7:0]; // see RULE1 see RULE3
                OFS_POLARITY: polarity_r <= wdata_r[7:0]; // see RULE2
                OFS_STATUS_CONTROL:
                begin
                    mode_r <= detect_mode_t'(wdata_r[SC_MODE_BIT]); // see RULE16 see RULE18
                    irq_enable_r <= wdata_r[SC_IE_BIT]; // see RULE16
                end
                OFS_EVT_ENABLE: evt_enable_r <= wdata_r[EVT_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    // Flag and acknowledge; a set in the same cycle beats the clear
    assign ack_wr = wr_lane0 && (awaddr_r == OFS_STATUS_CONTROL) && wdata_r[SC_ACK_BIT];
    assign ack_clear = ack_wr && !((mode_r == MODE_EDGE_LEVEL) && level_any); // see RULE10 see RULE12 see RULE13

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            event_flag_r <= RST_FLAG;
        end
        else if (ce)
        begin
            if (flag_set)
            begin
                event_flag_r <= 1'b1; // see RULE8 see RULE11
            end
            else if (ack_clear)
            begin
                event_flag_r <= 1'b0; // see RULE10 see RULE17
            end
        end
    end

    // Sticky event status with write-one clear
    assign evt_clear = (wr_lane0 && (awaddr_r == OFS_EVT_CLEAR)) ? wdata_r[EVT_W-1:0] : 2'h0;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            evt_status_r <= RST_EVT;
        end
        else if (ce)
        begin
            evt_status_r[EVT_EDGE_BIT] <= edge_hit | (evt_status_r[EVT_EDGE_BIT] & ~evt_clear[EVT_EDGE_BIT]);
            evt_status_r[EVT_LEVEL_BIT] <= level_hit | (evt_status_r[EVT_LEVEL_BIT] & ~evt_clear[EVT_LEVEL_BIT]);
        end
    end

    // Interrupt output
    assign irq = (event_flag_r && irq_enable_r) || (|(evt_status_r & evt_enable_r)); // see RULE9 see RULE19

    // Pull resistor selection
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pull_up_en <= 8'h00;
            pull_down_en <= 8'h00;
        end
        else if (ce)
        begin
            pull_up_en <= port_pull_enable & ~polarity_r; // see RULE14
            pull_down_en <= port_pull_enable & polarity_r; // see RULE14
        end
    end

    // Bus read channel
    assign s_axi_arready = ce && !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        unique case (s_axi_araddr)
            OFS_STATUS_CONTROL:
            begin
                // Upper bits and acknowledge read as zero
                rdata_nxt[SC_FLAG_BIT] = event_flag_r; // see RULE16 see RULE17
                rdata_nxt[SC_IE_BIT] = irq_enable_r;
                rdata_nxt[SC_MODE_BIT] = mode_r;
            end
            OFS_PIN_ENABLE: rdata_nxt[7:0] = pin_enable_r;
            OFS_POLARITY: rdata_nxt[7:0] = polarity_r;
            OFS_EVT_STATUS: rdata_nxt[EVT_W-1:0] = evt_status_r;
            OFS_EVT_ENABLE: rdata_nxt[EVT_W-1:0] = evt_enable_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
            raddr_r <= 8'h00;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rdata_nxt;
                raddr_r <= s_axi_araddr;
                rresp_r <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rvalid_r && s_axi_rready)
            begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Checks
    chk_irq_from_flag: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE9
        (evt_enable_r == 2'h0) |-> (irq == (event_flag_r && irq_enable_r)))
        else $error("irq does not follow flag and enable");

    chk_edge_sets_flag: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE8
        (ce && edge_hit) |=> event_flag_r)
        else $error("edge did not set flag");

    chk_rise_detect: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE6
        (ce && pin_enable_r[0] && polarity_r[0] && !$past(pin_sync_r[0]) && pin_sync_r[0]
         && !prev_act_r[0]) |=> event_flag_r)
        else $error("rising edge missed");

    chk_fall_detect: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE5
        (ce && pin_enable_r[0] && !polarity_r[0] && $past(pin_sync_r[0]) && !pin_sync_r[0]
         && !prev_act_r[0]) |=> event_flag_r)
        else $error("falling edge missed");

    chk_disabled_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE19
        (ce && pin_enable_r == 8'h00 && !event_flag_r) |=> !event_flag_r)
        else $error("flag set with no pin enabled");

    chk_edge_ack_clears: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE10
        (ce && mode_r == MODE_EDGE_ONLY && ack_wr && !edge_hit) |=> !event_flag_r)
        else $error("acknowledge failed to clear flag");

    chk_level_holds: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE13
        (ce && mode_r == MODE_EDGE_LEVEL && level_any && ack_wr) |=> event_flag_r)
        else $error("flag cleared while level asserted");

    chk_level_sets: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE11
        (ce && mode_r == MODE_EDGE_LEVEL && level_any) |=> event_flag_r)
        else $error("level did not set flag");

    chk_ack_reads_zero: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE17
        ($rose(rvalid_r) && raddr_r == OFS_STATUS_CONTROL) |-> (rdata_r[7:4] == 4'h0 && !rdata_r[2]))
        else $error("acknowledge or upper bits read nonzero");

    chk_pull_select: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE14
        ce |=> (pull_down_en == ($past(port_pull_enable) & $past(polarity_r))))
        else $error("pull selection wrong");

    chk_level_ack_clears: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE12
        (ce && mode_r == MODE_EDGE_LEVEL && ack_wr && !level_any) |=> !event_flag_r)
        else $error("acknowledge failed to clear flag with inputs inactive");

    chk_pull_up_select: assert property (@(posedge sys_clk) disable iff (!reset_n) // see RULE14
        ce |=> (pull_up_en == ($past(port_pull_enable) & ~$past(polarity_r))))
        else $error("pullup selection wrong");

endmodule : keypad_wake_unit
`default_nettype wire

// ---- test/wake_switch_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module wake_switch_bank
    import keypad_wake_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Switch settings from the bench
    input wire logic [NPINS-1:0] level,
    input wire logic [NPINS-1:0] drive,
    // Pull control from the unit
    input wire logic [NPINS-1:0] pull_up_en,
    input wire logic [NPINS-1:0] pull_down_en,
    // Pins
    output logic [NPINS-1:0] pins
);
    logic [NPINS-1:0] float_r = 8'h55;
    // Open pins without a pull wander every cycle
    always_ff @(posedge sys_clk)
        float_r <= ~float_r;
    // Released pins settle at the selected pull level
    assign pins = (drive & level) | (~drive & (pull_up_en | (~pull_down_en & float_r)));
endmodule : wake_switch_bank
`default_nettype wire

// ---- test/keyboard_pin_interrupt_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module keyboard_pin_interrupt_bench;
    import keypad_wake_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] level = 8'h00, drive = 8'hff, ppe = 8'h00, pu, pd, pins, awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rs;
    int err_count = 0, tests_run = 0;
    int i;
    keypad_wake_unit dut (.sys_clk(sys_clk), .reset_n(reset_n), .ce(ce), .wake_input_pin(pins),
        .port_pull_enable(ppe), .pull_up_en(pu), .pull_down_en(pd), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    wake_switch_bank sw (.sys_clk(sys_clk), .level(level), .drive(drive), .pull_up_en(pu),
        .pull_down_en(pd), .pins(pins));
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude;
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic fail_out;
        err_count++;
        conclude();
    endtask : fail_out
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw, w, b;
        b = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40 && !b; n++)
        begin
            @(negedge sys_clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            rs = bresp;
            @(posedge sys_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
        if (!b) fail_out();
    endtask : wr
    task automatic rdw(input logic [7:0] a);
        int n;
        logic ar, r;
        r = 1'b0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40 && !r; n++)
        begin
            @(negedge sys_clk);
            ar = arvalid && arready;
            r = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge sys_clk);
            if (ar) arvalid <= 1'b0;
            if (r) rready <= 1'b0;
        end
        if (!r) fail_out();
    endtask : rdw
    task automatic wait_irq(input logic v);
        int n;
        for (n = 0; n < 16 && irq !== v; n++)
            @(negedge sys_clk);
        if (irq !== v) fail_out();
    endtask : wait_irq
    task automatic t_reset;
        logic [7:0] ofs [5] = '{OFS_STATUS_CONTROL, OFS_PIN_ENABLE, OFS_POLARITY, OFS_EVT_STATUS, OFS_EVT_ENABLE};
        foreach (ofs[k])
        begin
            rdw(ofs[k]);
            chk(rd, 32'h0);
        end
        rdw(8'h40);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(8'h40, 32'hff);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        chk({31'h0, irq}, 32'h0);
    endtask : t_reset
    task automatic t_arm;
        // Pin 0 held asserted since reset gives no edge
        wr(OFS_PIN_ENABLE, 32'h01);
        wr(OFS_STATUS_CONTROL, 32'h06);
        repeat (8) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        level <= 8'hff;
        repeat (4) @(posedge sys_clk);
        level <= 8'h00;
        wait_irq(1'b1);
        wr(OFS_STATUS_CONTROL, 32'h04);
        level <= 8'hff;
    endtask : t_arm
    task automatic t_regs;
        wr(OFS_PIN_ENABLE, 32'hff);
        rdw(OFS_PIN_ENABLE);
        chk(rd, 32'hff);
        wr(OFS_POLARITY, 32'ha5);
        rdw(OFS_POLARITY);
        chk(rd, 32'ha5);
        wr(OFS_PIN_ENABLE, 32'h00);
        wr(OFS_STATUS_CONTROL, 32'hff);
        rdw(OFS_STATUS_CONTROL);
        chk(rd, 32'h03);
        ppe <= 8'hff;
        repeat (3) @(posedge sys_clk);
        chk({24'h0, pu}, 32'h5a);
        chk({24'h0, pd}, 32'ha5);
        ppe <= 8'h00;
        wr(OFS_STATUS_CONTROL, 32'h00);
        wr(OFS_PIN_ENABLE, 32'h00);
        wr(OFS_POLARITY, 32'h00);
    endtask : t_regs
    task automatic t_edge(input int p, input logic pol);
        level <= pol ? 8'h00 : 8'hff;
        // Safe bring-up order
        wr(OFS_STATUS_CONTROL, 32'h00);
        wr(OFS_POLARITY, pol ? 32'h1 << p : 32'h0);
        wr(OFS_PIN_ENABLE, 32'h1 << p);
        wr(OFS_STATUS_CONTROL, 32'h04);
        wr(OFS_STATUS_CONTROL, 32'h02);
        chk({31'h0, irq}, 32'h0);
        level[p] <= pol;
        wait_irq(1'b1);
        rdw(OFS_STATUS_CONTROL);
        chk(rd, 32'h0a);
        wr(OFS_STATUS_CONTROL, 32'h06);
        chk({31'h0, irq}, 32'h0);
        rdw(OFS_STATUS_CONTROL);
        chk(rd, 32'h02);
        level[p] <= ~pol;
    endtask : t_edge
    task automatic t_disabled;
        wr(OFS_POLARITY, 32'h00);
        wr(OFS_PIN_ENABLE, 32'h01);
        wr(OFS_STATUS_CONTROL, 32'h06);
        level <= 8'hf7;
        repeat (8) @(posedge sys_clk);
        level <= 8'hff;
        repeat (8) @(posedge sys_clk);
        rdw(OFS_STATUS_CONTROL);
        chk(rd, 32'h02);
    endtask : t_disabled
    task automatic t_level;
        wr(OFS_STATUS_CONTROL, 32'h04);
        wr(OFS_STATUS_CONTROL, 32'h03);
        level <= 8'hfe;
        wait_irq(1'b1);
        wr(OFS_STATUS_CONTROL, 32'h07);
        rdw(OFS_STATUS_CONTROL);
        chk(rd, 32'h0b);
        level <= 8'hff;
        repeat (4) @(posedge sys_clk);
        wr(OFS_STATUS_CONTROL, 32'h07);
        rdw(OFS_STATUS_CONTROL);
        chk(rd, 32'h03);
        chk({31'h0, irq}, 32'h0);
    endtask : t_level
    task automatic t_events;
        wr(OFS_STATUS_CONTROL, 32'h04);
        wr(OFS_EVT_CLEAR, 32'h03);
        wr(OFS_EVT_ENABLE, 32'h01);
        chk({31'h0, irq}, 32'h0);
        level <= 8'hfe;
        wait_irq(1'b1);
        rdw(OFS_EVT_STATUS);
        chk(rd & 32'h1, 32'h1);
        wr(OFS_EVT_ENABLE, 32'h00);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_EVT_CLEAR, 32'h01);
        rdw(OFS_EVT_STATUS);
        chk(rd & 32'h1, 32'h0);
        rdw(OFS_EVT_CLEAR);
        chk(rd, 32'h0);
        wr(OFS_STATUS_CONTROL, 32'h04);
        level <= 8'hff;
    endtask : t_events
    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_arm();
        t_regs();
        for (i = 0; i < 8; i++)
            t_edge(i, i[0]);
        t_disabled();
        t_level();
        t_events();
        conclude();
    end
endmodule : keyboard_pin_interrupt_bench
`default_nettype wire
